// ---- iqs_cfg.svh ----
// Constants for the instruction queue status block
// Function
// R1 - Start needs at least three queued bytes
// R2 - Finish current instruction before next start
// R3 - Move code at E rise, start at fall
// R4 - Move codes: none, latch, advance bus/latch
// R5 - Start code zero when nothing starts
// R6 - Move code describes data at previous fall
// R7 - Start code describes cycle at that fall
// R8 - Two 16-bit stages plus holding latch
// R9 - Advance shifts stage one, reloads it
// R10 - Even uses high byte, odd low byte
// R11 - Only fetched data buffered, no addresses
// R12 - Trace logic rebuilds queue with addresses
// R13 - Nonzero start codes: interrupt, even, odd
`ifndef IQS_CFG_SVH
`define IQS_CFG_SVH

// ****************************************
// Codes on the status pair
// ****************************************
`define IQS_MV_NONE      2'h0
`define IQS_MV_LATCH     2'h1
`define IQS_MV_ADV_BUS   2'h2
`define IQS_MV_ADV_LATCH 2'h3
`define IQS_ST_NONE      2'h0
`define IQS_ST_INT       2'h1
`define IQS_ST_EVEN      2'h2
`define IQS_ST_ODD       2'h3

// ****************************************
// Widths and reset values
// ****************************************
`define IQS_WORD_W       16
`define IQS_WORD_RST     16'h0000
`define IQS_BYTE_RST     8'h00

// ****************************************
// Bus cycle clock timing
// ****************************************
`define IQS_REF_PERIOD_NS 10
`define IQS_BUS_CYCLE_CLOCK_HALF_NS  20
`define IQS_BUS_CYCLE_CLOCK_HALF_CYC ((`IQS_BUS_CYCLE_CLOCK_HALF_NS + `IQS_REF_PERIOD_NS - 1) / `IQS_REF_PERIOD_NS)
`define IQS_DIV_W         3

`endif

// ---- iqs_pkg.sv ----
// Types shared by the instruction queue status block
`default_nettype none
package iqs_pkg;
	typedef logic [1:0] iqs_code_t;
	typedef enum logic {IQS_PH_LOW, IQS_PH_HIGH} iqs_phase_t;
endpackage : iqs_pkg
`default_nettype wire

// ---- iqs_bus_cycle_clock_gen.sv ----
// Bus cycle clock divider with edge enable pulses
`timescale 1ns/100ps
`default_nettype none
`include "iqs_cfg.svh"
module iqs_bus_cycle_clock_gen (
	input  wire logic clk_i,
	input  wire logic srst_i,
	output logic      bus_cycle_clock_o,
	output logic      rise_o,
	output logic      fall_o
);
	logic [`IQS_DIV_W-1:0] cnt_q;
	logic                  bus_cycle_clock_q;
	logic                  term;

	// Half period can never be below one reference cycle
	assign term   = (cnt_q == `IQS_DIV_W'(`IQS_BUS_CYCLE_CLOCK_HALF_CYC - 1));
	assign rise_o = term & ~bus_cycle_clock_q;
	assign fall_o = term & bus_cycle_clock_q;
	assign bus_cycle_clock_o = bus_cycle_clock_q;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			cnt_q  <= '0;
			bus_cycle_clock_q <= 1'b0;
		end else if (term) begin
			cnt_q  <= '0;
			bus_cycle_clock_q <= ~bus_cycle_clock_q;
		end else begin
			cnt_q  <= cnt_q + `IQS_DIV_W'(1);
		end
	end
endmodule : iqs_bus_cycle_clock_gen
`default_nettype wire

// ---- iqs_queue_status.sv ----
// Instruction prefetch queue with time-multiplexed status pair
`timescale 1ns/100ps
`default_nettype none
`include "iqs_cfg.svh"
module iqs_queue_status (
	input  wire logic                   REF_CLK_I,
	input  wire logic                   SRST_I,
	input  wire logic [`IQS_WORD_W-1:0] BUS_DATA_I,
	input  wire logic [1:0]             MOVE_REQ_I,
	input  wire logic [1:0]             START_REQ_I,
	input  wire logic                   FLUSH_I,
	input  wire logic                   INSN_DONE_I,
	output logic                        BUS_CYCLE_CLOCK_O,
	output logic [1:0]                  QUEUE_STATUS_PAIR_O,
	output logic [`IQS_WORD_W-1:0]      STAGE1_O,
	output logic [`IQS_WORD_W-1:0]      STAGE2_O,
	output logic [`IQS_WORD_W-1:0]      HOLD_LATCH_O,
	output logic                        QUEUE_READY_O,
	output logic                        EXEC_START_O,
	output logic [1:0]                  EXEC_KIND_O,
	output logic [7:0]                  OPCODE_O,
	output logic                        BUSY_O
);
	// ****************************************
	// Bus cycle clock
	// ****************************************
	logic bus_cycle_clock;
	logic rise_en;
	logic fall_en;

	iqs_bus_cycle_clock_gen u_bus_cycle_clock (
		.clk_i  (REF_CLK_I),
		.srst_i (SRST_I),
		.bus_cycle_clock_o (bus_cycle_clock),
		.rise_o (rise_en),
		.fall_o (fall_en)
	);

	// ****************************************
	// Queue storage
	// ****************************************
	// R11 data only
	// Only fetched words are held; trace logic pairs them with addresses itself
	logic [`IQS_WORD_W-1:0] s1_q;
	logic [`IQS_WORD_W-1:0] s2_q;
	logic [`IQS_WORD_W-1:0] lat_q;
	logic [`IQS_WORD_W-1:0] bus_word_q;
	logic                   s1_v_q;
	logic                   s2_v_q;
	logic                   lat_v_q;
	iqs_pkg::iqs_code_t     move_q;
	iqs_pkg::iqs_code_t     start_q;
	iqs_pkg::iqs_code_t     pins_q;
	iqs_pkg::iqs_phase_t    phase_q;
	logic                   busy_q;
	logic                   exec_q;
	logic [1:0]             kind_q;
	logic [7:0]             opcode_q;

	// ****************************************
	// Decode
	// ****************************************
	logic                   advance;
	logic                   from_latch;
	logic                   bytes_ok;
	logic                   start_ok;
	logic                   code_start;
	iqs_pkg::iqs_code_t     move_ok;
	iqs_pkg::iqs_code_t     start_code;
	logic [`IQS_WORD_W-1:0] s1_src;
	logic [7:0]             start_byte;

	// R4 movement legality
	// Loading from an empty or just flushed latch would feed stale data, so it degrades to no move
	assign move_ok    = (MOVE_REQ_I == `IQS_MV_ADV_LATCH && (!lat_v_q || FLUSH_I)) ? `IQS_MV_NONE : MOVE_REQ_I;
	assign advance    = (move_q == `IQS_MV_ADV_BUS) || (move_q == `IQS_MV_ADV_LATCH);
	assign from_latch = (move_q == `IQS_MV_ADV_LATCH);
	// R9 stage one source
	assign s1_src     = from_latch ? lat_q : bus_word_q;
	// R1 three bytes present
	// Both stages valid gives four bytes, or three from an odd start
	assign bytes_ok   = s1_v_q & s2_v_q;
	assign QUEUE_READY_O = bytes_ok;
	// R2 no overlap
	assign code_start = (START_REQ_I != `IQS_ST_NONE) && !busy_q;
	// R13 interrupt start needs no opcode bytes
	assign start_ok   = code_start && ((START_REQ_I == `IQS_ST_INT) || bytes_ok);
	// R5 zero when idle
	assign start_code = start_ok ? START_REQ_I : `IQS_ST_NONE;
	// R10 byte select
	assign start_byte = (start_q == `IQS_ST_ODD) ? s2_q[7:0] :
	                    (start_q == `IQS_ST_EVEN) ? s2_q[15:8] : `IQS_BYTE_RST;

	// ****************************************
	// Status pair multiplexing
	// ****************************************
	// R3 time multiplexing
	// Pins change with the E edge itself, so each code holds through the whole phase that ends at the edge that latches it
	always_ff @(posedge REF_CLK_I) begin
		if (SRST_I) begin
			pins_q  <= `IQS_MV_NONE;
			phase_q <= iqs_pkg::IQS_PH_LOW;
		end else if (fall_en) begin
			pins_q  <= move_ok;
			phase_q <= iqs_pkg::IQS_PH_LOW;
		end else if (rise_en) begin
			pins_q  <= start_code;
			phase_q <= iqs_pkg::IQS_PH_HIGH;
		end
	end

	// R6 sample at fall
	always_ff @(posedge REF_CLK_I) begin
		if (SRST_I) begin
			bus_word_q <= `IQS_WORD_RST;
			move_q     <= `IQS_MV_NONE;
		end else if (fall_en) begin
			bus_word_q <= BUS_DATA_I;
			move_q     <= move_ok;
		end
	end

	// ****************************************
	// Queue movement
	// ****************************************
	// R8 stages and latch
	always_ff @(posedge REF_CLK_I) begin
		if (SRST_I) begin
			s1_q    <= `IQS_WORD_RST;
			s2_q    <= `IQS_WORD_RST;
			lat_q   <= `IQS_WORD_RST;
			s1_v_q  <= 1'b0;
			s2_v_q  <= 1'b0;
			lat_v_q <= 1'b0;
		end else if (fall_en && FLUSH_I) begin
			s1_v_q  <= 1'b0;
			s2_v_q  <= 1'b0;
			lat_v_q <= 1'b0;
		end else if (rise_en && move_q == `IQS_MV_LATCH) begin
			lat_q   <= bus_word_q;
			lat_v_q <= 1'b1;
		end else if (rise_en && advance) begin
			// R9 advance queue
			s2_q    <= s1_q;
			s2_v_q  <= s1_v_q;
			s1_q    <= s1_src;
			s1_v_q  <= 1'b1;
			lat_v_q <= lat_v_q & ~from_latch;
		end
	end

	// ****************************************
	// Execution start
	// ****************************************
	// R7 start at fall
	// The code shown in the high phase takes effect at the fall that ends it
	always_ff @(posedge REF_CLK_I) begin
		if (SRST_I) begin
			start_q <= `IQS_ST_NONE;
		end else if (rise_en) begin
			start_q <= start_code;
		end else if (fall_en) begin
			start_q <= `IQS_ST_NONE;
		end
	end

	// R2 busy until done
	// A start at the fall wins over done in the same cycle; starts are only shown while not busy, so overlap can never appear
	always_ff @(posedge REF_CLK_I) begin
		if (SRST_I) begin
			busy_q   <= 1'b0;
			exec_q   <= 1'b0;
			kind_q   <= `IQS_ST_NONE;
			opcode_q <= `IQS_BYTE_RST;
		end else begin
			exec_q <= fall_en && (start_q != `IQS_ST_NONE);
			if (fall_en && start_q != `IQS_ST_NONE) begin
				busy_q   <= 1'b1;
				kind_q   <= start_q;
				opcode_q <= start_byte;
			end else if (INSN_DONE_I) begin
				busy_q   <= 1'b0;
			end
		end
	end

	assign BUS_CYCLE_CLOCK_O   = bus_cycle_clock;
	assign QUEUE_STATUS_PAIR_O = pins_q;
	assign STAGE1_O            = s1_q;
	assign STAGE2_O            = s2_q;
	assign HOLD_LATCH_O        = lat_q;
	assign EXEC_START_O        = exec_q;
	assign EXEC_KIND_O         = kind_q;
	assign OPCODE_O            = opcode_q;
	assign BUSY_O              = busy_q;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (SRST_I);

	move_phase_a: assert property (fall_en |=> QUEUE_STATUS_PAIR_O == move_q) // R3
		else $error("move code not shown in low phase");
	idle_zero_a: assert property (rise_en && !start_ok |=> QUEUE_STATUS_PAIR_O == 2'h0) // R5
		else $error("nonzero start code with no start");
	latch_load_a: assert property (rise_en && move_q == 2'h1 |=> HOLD_LATCH_O == $past(bus_word_q)) // R8
		else $error("latch not loaded from bus word");
	advance_bus_a: assert property (rise_en && move_q == 2'h2 && !$past(FLUSH_I) // R9
		|=> STAGE2_O == $past(s1_q) && STAGE1_O == $past(bus_word_q))
		else $error("advance from bus wrong");
	fall_data_a: assert property (fall_en ##1 (!fall_en)[*2] ##0 rise_en && move_q == 2'h2 // R6
		|=> STAGE1_O == $past(BUS_DATA_I, 3))
		else $error("move does not use data from previous fall");
	start_shown_a: assert property (phase_q == iqs_pkg::IQS_PH_HIGH |-> QUEUE_STATUS_PAIR_O == start_q) // R7
		else $error("shown start code differs from the one taken at fall");
	latch_valid_a: assert property (rise_en && move_q == 2'h3 |-> lat_v_q) // R4
		else $error("advance from empty latch");
	start_bytes_a: assert property (EXEC_START_O && EXEC_KIND_O != 2'h1 |-> $past(s1_v_q && s2_v_q)) // R1
		else $error("start with fewer than three bytes");
	no_overlap_a: assert property (EXEC_START_O |-> !$past(busy_q)) // R2
		else $error("start while previous instruction busy");
	start_fall_a: assert property (rise_en && start_code != 2'h0 |-> ##[1:4] EXEC_START_O) // R7
		else $error("shown start not taken at next fall");
	even_byte_a: assert property (EXEC_START_O && EXEC_KIND_O == 2'h2 |-> OPCODE_O == $past(s2_q[15:8])) // R10
		else $error("even start took wrong byte");
	odd_code_a: assert property (EXEC_START_O |-> EXEC_KIND_O == $past(start_q)) // R13
		else $error("start kind differs from shown code");

	cover_even_c: cover property (EXEC_START_O && EXEC_KIND_O == 2'h2);
	cover_odd_c: cover property (EXEC_START_O && EXEC_KIND_O == 2'h3);
	cover_all_c: cover property (rise_en && move_q == 2'h3);
	cover_lat_c: cover property (rise_en && move_q == 2'h1 ##[1:40] rise_en && move_q == 2'h3);
endmodule : iqs_queue_status
`default_nettype wire

// ---- iqs_trace_model.sv ----
// Trace-side model rebuilding the queue from the status pair
`timescale 1ns/100ps
`default_nettype none
`include "iqs_cfg.svh"
module iqs_trace_model (
	input  wire logic                   clk_i,
	input  wire logic                   srst_i,
	input  wire logic                   bus_cycle_clock_i,
	input  wire logic [1:0]             pair_i,
	input  wire logic [`IQS_WORD_W-1:0] data_i,
	output logic [`IQS_WORD_W-1:0]      s1_o,
	output logic [`IQS_WORD_W-1:0]      s2_o,
	output logic [`IQS_WORD_W-1:0]      lat_o,
	output logic [1:0]                  mv_o,
	output logic [1:0]                  st_o,
	output logic                        mv_seen_o,
	output logic                        st_seen_o
);
	logic                   e_q;
	logic [1:0]             pair_q;
	logic [`IQS_WORD_W-1:0] bus_q;
	logic [`IQS_WORD_W-1:0] word_q;
	wire                    rose = !e_q && bus_cycle_clock_i;
	wire                    fell = e_q && !bus_cycle_clock_i;
	// codes held just before each E edge
	always_ff @(posedge clk_i) begin
		e_q <= bus_cycle_clock_i;
		pair_q <= pair_i;
		bus_q <= data_i;
		mv_seen_o <= rose && !srst_i;
		st_seen_o <= fell && !srst_i;
		if (srst_i) begin
			s1_o <= `IQS_WORD_RST;
			s2_o <= `IQS_WORD_RST;
			lat_o <= `IQS_WORD_RST;
			mv_o <= `IQS_MV_NONE;
			st_o <= `IQS_ST_NONE;
		end else begin
			// word on bus at fall feeds next move
			if (fell)
				word_q <= bus_q;
			if (fell)
				st_o <= pair_q;
			if (rose) begin
				mv_o <= pair_q;
				if (pair_q == `IQS_MV_LATCH)
					lat_o <= word_q;
				if (pair_q[1]) begin
					s2_o <= s1_o;
					s1_o <= pair_q[0] ? lat_o : word_q;
				end
			end
		end
	end
endmodule : iqs_trace_model
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the instruction queue status block
`timescale 1ns/100ps
`default_nettype none
`include "iqs_cfg.svh"
module testbench;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        flush = 1'b0;
	logic        done = 1'b0;
	logic        auto = 1'b1;
	logic        ecl, rdy, xs, busy, ms, ss, e_q, busy_q, rdy_q, xs_q;
	logic [1:0]  mv = 2'h0;
	logic [1:0]  st = 2'h0;
	logic [1:0]  pair, kind, m_mv, m_st, m, pm;
	logic [2:0]  em, es;
	logic [7:0]  op;
	logic [15:0] data = 16'h0000;
	logic [15:0] s1, s2, hl, m1, m2, ml;
	logic [31:0] seed = 32'h0000_003C;
	logic [31:0] r;
	logic [2:0]  q_mv[$];
	logic [2:0]  q_st[$];
	int          error_cnt = 0;
	int          checks = 0;
	int          cyc = 0;

	iqs_queue_status dut (.REF_CLK_I(clk), .SRST_I(rst), .BUS_DATA_I(data), .MOVE_REQ_I(mv),
		.START_REQ_I(st), .FLUSH_I(flush), .INSN_DONE_I(done), .BUS_CYCLE_CLOCK_O(ecl),
		.QUEUE_STATUS_PAIR_O(pair), .STAGE1_O(s1), .STAGE2_O(s2), .HOLD_LATCH_O(hl),
		.QUEUE_READY_O(rdy), .EXEC_START_O(xs), .EXEC_KIND_O(kind), .OPCODE_O(op), .BUSY_O(busy));
	iqs_trace_model trace (.clk_i(clk), .srst_i(rst), .bus_cycle_clock_i(ecl), .pair_i(pair), .data_i(data),
		.s1_o(m1), .s2_o(m2), .lat_o(ml), .mv_o(m_mv), .st_o(m_st), .mv_seen_o(ms), .st_seen_o(ss));

	initial forever #5 clk = ~clk;

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic final_report;
		if (error_cnt == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : final_report

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	// even takes the high byte, odd the low
	function automatic logic [7:0] exp_op(input logic [1:0] c, input logic [15:0] w);
		return (c == `IQS_ST_EVEN) ? w[15:8] : (c == `IQS_ST_ODD) ? w[7:0] : 8'h00;
	endfunction : exp_op

	// One E cycle of requests, launched just after an E fall; expected codes queued
	task automatic c(input logic [1:0] mq, input logic [1:0] sq, input logic [2:0] emq, input logic [2:0] esq,
		input logic [15:0] d = 16'h0000, input logic f = 1'b0);
		do @(posedge clk); while (!(e_q && !ecl));
		mv <= mq;
		st <= sq;
		data <= d;
		flush <= f;
		if (q_mv.size() == 0) begin
			q_mv.push_back(3'h0);
			q_st.push_back(3'h0);
		end
		q_mv.push_back(emq);
		q_st.push_back(esq);
	endtask : c

	always @(posedge clk) begin
		e_q <= ecl;
		done <= auto && busy && !done;
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			error_cnt++;
			final_report();
		end
	end

	always @(negedge clk) begin
		if (ms) begin
			em = q_mv.size() ? q_mv.pop_front() : 3'h0;
			check("move code", m_mv, em[1:0]);
			check("stage one", s1, m1);
			check("stage two", s2, m2);
			check("hold latch", hl, ml);
		end
		if (ss) begin
			es = q_st.size() ? q_st.pop_front() : 3'h0;
			if (!es[2])
				check("start code", m_st, es[1:0]);
			check("start pulse", xs_q, m_st != 2'h0);
			if (m_st != 2'h0)
				check("start kind", kind, m_st);
			if (m_st != 2'h0)
				check("opcode", op, exp_op(m_st, m2));
			if (m_st[1])
				check("ready at start", rdy_q, 1'b1);
		end
		if (xs)
			check("start while busy", busy_q, 1'b0);
		rdy_q <= rdy;
		busy_q <= busy;
		xs_q <= xs;
	end

	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		#1;
		check("reset outputs", {ecl, pair, rdy, xs, busy, kind, op}, 16'h0000);
		c(`IQS_MV_ADV_LATCH, `IQS_ST_EVEN, 3'h0, 3'h0);
		c(`IQS_MV_NONE, `IQS_ST_INT, 3'h0, 3'h1);
		c(`IQS_MV_LATCH, `IQS_ST_NONE, 3'h1, 3'h0, 16'h1234);
		c(`IQS_MV_ADV_BUS, `IQS_ST_NONE, 3'h2, 3'h0, 16'hABCD);
		c(`IQS_MV_ADV_LATCH, `IQS_ST_NONE, 3'h3, 3'h0);
		for (int k = 0; k < 6; k++) begin
			m = (k == 1) ? `IQS_ST_EVEN : (k == 3) ? `IQS_ST_ODD : `IQS_ST_NONE;
			c(`IQS_MV_NONE, m, 3'h0, {1'b0, m});
		end
		auto <= 1'b0;
		c(`IQS_MV_NONE, `IQS_ST_EVEN, 3'h0, 3'h2);
		c(`IQS_MV_NONE, `IQS_ST_NONE, 3'h0, 3'h0);
		c(`IQS_MV_NONE, `IQS_ST_ODD, 3'h0, 3'h0);
		auto <= 1'b1;
		pm = 2'h0;
		for (int i = 0; i < 40; i++) begin
			r = rnd();
			m = (pm == `IQS_MV_LATCH && r[8]) ? `IQS_MV_ADV_LATCH : 2'(r[1:0] % 3);
			c(m, r[3:2], {1'b0, m}, 3'h4, r[31:16]);
			pm = m;
		end
		c(`IQS_MV_ADV_LATCH, `IQS_ST_NONE, 3'h0, 3'h0, 16'h0000, 1'b1);
		c(`IQS_MV_NONE, `IQS_ST_NONE, 3'h0, 3'h0);
		check("ready after flush", rdy, 1'b0);
		c(`IQS_MV_NONE, `IQS_ST_EVEN, 3'h0, 3'h0);
		c(`IQS_MV_NONE, `IQS_ST_NONE, 3'h0, 3'h0);
		c(`IQS_MV_NONE, `IQS_ST_NONE, 3'h0, 3'h0);
		final_report();
	end
endmodule : testbench
`default_nettype wire
